// >>> include/instr_state_regs.vh
// Constants for the instruction-state switch and byte-lane steering
`ifndef INSTR_STATE_REGS_VH
`define INSTR_STATE_REGS_VH
// State flag encodings
`define STATE_WIDE          1'b0
`define STATE_COMPACT       1'b1
// Operand bit that selects the state on a branch-exchange
`define BX_STATE_BIT        0
// Program counter bit that picks the halfword in compact state
`define PC_HALF_BIT         1
// Program counter increments in bytes
`define PC_STEP_WIDE        32'h00000004
`define PC_STEP_COMPACT     32'h00000002
// Program counter value after reset
`define PC_RESET            32'h00000000
// Exception vector addresses
`define VEC_RESET           32'h00000000
`define VEC_UNDEFINED_INSTRUCTION_TRAP           32'h00000004
`define VEC_SWI             32'h00000008
`define VEC_PABORT          32'h0000000C
`define VEC_DABORT          32'h00000010
`define VEC_IRQ             32'h00000018
`define VEC_FIQ             32'h0000001C
// Exception cause codes
`define EXC_RESET           3'h0
`define EXC_UNDEFINED_INSTRUCTION_TRAP           3'h1
`define EXC_SWI             3'h2
`define EXC_PABORT          3'h3
`define EXC_DABORT          3'h4
`define EXC_IRQ             3'h5
`define EXC_FIQ             3'h6
// Processor mode codes
`define MODE_USR            5'h10
`define MODE_FIQ            5'h11
`define MODE_IRQ            5'h12
`define MODE_SVC            5'h13
`define MODE_ABT            5'h17
`define MODE_UND            5'h1B
`endif

// >>> hw/byte_lane_steer.v
// Byte-lane steering between the 32-bit data bus and byte addresses
`include "instr_state_regs.vh"
module byte_lane_steer
(
    // Byte order and address
    input  wire        bigEndian,
    input  wire [1:0]  byteAddr,
    // Bus word in
    input  wire [31:0] busWord,
    // Selected byte and halfword
    output reg  [7:0]  byteOut,
    output reg  [15:0] halfOut
);
    // Lane number counted from the low bits of the bus
    reg [1:0] laneIdx;

    // Byte 0 sits on the top lane in big-endian, bottom lane in little
    always @*
    begin
        laneIdx = bigEndian ? ~byteAddr : byteAddr;
        byteOut = busWord[laneIdx*8 +: 8];
        // Halfword at address 0 is the upper half in big-endian order
        if (bigEndian ^ byteAddr[1])
            halfOut = busWord[31:16];
        else
            halfOut = busWord[15:0];
    end
endmodule // byte_lane_steer

// >>> hw/instruction_state_switch.v
// Instruction-state control: wide/compact state, exceptions, fetch path
//
// Overview of operation
// - Wide state runs word-aligned 32-bit instructions
// - Compact state runs halfword-aligned 16-bit instructions
// - Compact state: PC bit 1 picks halfword
// - State switch keeps mode and registers unchanged
// - Branch-exchange with bit 0 set: compact
// - Exception return restores compact if taken there
// - Branch-exchange with bit clear: wide state
// - Any exception, reset included, forces wide state
// - Exception saves PC to link, jumps vector
// - Memory is byte array, four bytes per word
// - Words stored big- or little-endian as configured
// - Big-endian byte 0 on lines 31:24
// - Little-endian byte 0 on lines 7:0
//
// Timing at a glance
// Edge 0: reset released, pc at the reset vector, wide state
// Edge 1: fetch request raised for the word holding pc
// Edge 2: memory answers with the word valid for one cycle
// Edge 3: instruction held valid, compact ones zero-extended
// Advance seen at edge 4: pc steps at that edge and a refetch starts
//
// Flow events are sampled on the rising edge, one per cycle:
// exception entry first, then exception return, then branch-exchange,
// then advance. A lower event in the same cycle is simply dropped, so
// the surrounding core must not rely on two of them landing together.
//
// Exception entry copies the old pc to the link output for one cycle
// and moves to the vector in the same edge. The state flag of the
// interrupted code is kept per exception mode slot, so a return from
// that mode brings back the compact state if it was active at entry.
// Modes that share a slot (reset and software trap, prefetch and data abort) overwrite each
// other; nesting two exceptions of one mode loses the outer state,
// just as a single saved copy per mode would in software.
//
// The fetch path reads whole words only. In compact state the
// halfword is cut out by pc bit 1 through the byte-lane steering, so
// the byte order strap decides which bus half carries it.
// An answer arriving in the same cycle as a flow change is ignored,
// which costs one fetch; a word launched at the change edge still comes from the old path and is issued.
//
`include "instr_state_regs.vh"
module instruction_state_switch
(
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Byte order strap
    input  wire        bigEndian,
    // Instruction fetch port
    output wire [31:0] fetchAddr,
    output reg         fetchReq,
    input  wire        fetchValid,
    input  wire [31:0] fetchWord,
    // Decoded instruction out
    output reg  [31:0] instrOut,
    output reg         instrValid,
    output reg         instrCompact,
    input  wire        advance,
    // Branch-exchange request
    input  wire        branchExchange,
    input  wire [31:0] branchOperand,
    // Exception request
    input  wire        excReq,
    input  wire [2:0]  excCause,
    // Exception return
    input  wire        excReturn,
    input  wire [31:0] excReturnAddr,
    // State and mode view
    output reg         stateFlag,
    output reg  [4:0]  procMode,
    output reg  [31:0] linkValue,
    output reg         linkWrite,
    output reg  [31:0] pc
);
    // Saved state flag per exception mode
    reg [5:0]  savedState;
    // Vector and mode chosen for the pending cause
    reg [31:0] excVector;
    reg [4:0]  excMode;
    reg [2:0]  excSlot;
    // Previous mode per exception slot, for return
    reg [4:0]  savedMode [0:5];
    // Next values
    reg [31:0] next_pc;
    reg        next_state;
    // Selected halfword from the steering block
    wire [15:0] halfSel;
    // Slot of the mode now active
    reg [2:0]  curSlot;
    integer    i;

    // Word-aligned fetch address: the low bits never reach memory
    assign fetchAddr = {pc[31:2], 2'b00};

    // Halfword pick through the lane steering, by PC bit 1
    byte_lane_steer uSteer
    (
        .bigEndian (bigEndian),
        .byteAddr  ({pc[`PC_HALF_BIT], 1'b0}),
        .busWord   (fetchWord),
        .byteOut   (),
        .halfOut   (halfSel)
    );
    // Map cause to vector, mode and saved-state slot
    always @*
    begin
        case (excCause)
            `EXC_RESET:
            begin
                // Reset enters supervisor at the lowest vector
                excVector = `VEC_RESET;
                excMode   = `MODE_SVC;
                excSlot   = 3'h0;
            end
            `EXC_UNDEFINED_INSTRUCTION_TRAP:
            begin
                // Unknown opcode trap
                excVector = `VEC_UNDEFINED_INSTRUCTION_TRAP;
                excMode   = `MODE_UND;
                excSlot   = 3'h1;
            end
            `EXC_SWI:
            begin
                // Software trap shares the supervisor slot
                excVector = `VEC_SWI;
                excMode   = `MODE_SVC;
                excSlot   = 3'h0;
            end
            `EXC_PABORT:
            begin
                // Fetch abort
                excVector = `VEC_PABORT;
                excMode   = `MODE_ABT;
                excSlot   = 3'h2;
            end
            `EXC_DABORT:
            begin
                // Data abort shares the abort slot
                excVector = `VEC_DABORT;
                excMode   = `MODE_ABT;
                excSlot   = 3'h2;
            end
            `EXC_IRQ:
            begin
                // Normal interrupt
                excVector = `VEC_IRQ;
                excMode   = `MODE_IRQ;
                excSlot   = 3'h3;
            end
            `EXC_FIQ:
            begin
                // Fast interrupt
                excVector = `VEC_FIQ;
                excMode   = `MODE_FIQ;
                excSlot   = 3'h4;
            end
            default:
            begin
                // Unused cause code treated as an unknown opcode
                excVector = `VEC_UNDEFINED_INSTRUCTION_TRAP;
                excMode   = `MODE_UND;
                excSlot   = 3'h1;
            end
        endcase
    end

    // Slot of the current exception mode, used on return
    always @*
    begin
        case (procMode)
            `MODE_SVC: curSlot = 3'h0;
            `MODE_UND: curSlot = 3'h1;
            `MODE_ABT: curSlot = 3'h2;
            `MODE_IRQ: curSlot = 3'h3;
            `MODE_FIQ: curSlot = 3'h4;
            default:   curSlot = 3'h5;
        endcase
    end

    // Next PC and state: exception beats return beats branch beats step
    // Targets are forced to the alignment of the state they enter, so
    // a stray low bit in an operand never produces an odd fetch.
    // Registers other than pc and the state flag are never touched here.
    always @*
    begin
        next_pc    = pc;
        next_state = stateFlag;
        if (excReq)
        begin
            next_pc    = excVector;
            next_state = `STATE_WIDE;
        end
        else if (excReturn)
        begin
            next_state = savedState[curSlot];
            // Align to the restored state
            if (savedState[curSlot] == `STATE_COMPACT)
                next_pc = {excReturnAddr[31:1], 1'b0};
            else
                next_pc = {excReturnAddr[31:2], 2'b00};
        end
        else if (branchExchange)
        begin
            if (branchOperand[`BX_STATE_BIT])
            begin
                next_state = `STATE_COMPACT;
                next_pc    = {branchOperand[31:1], 1'b0};
            end
            else
            begin
                next_state = `STATE_WIDE;
                next_pc    = {branchOperand[31:2], 2'b00};
            end
        end
        else if (instrValid && advance)
        begin
            // Step size follows the single state flag
            next_pc = pc + ((stateFlag == `STATE_COMPACT) ?
                      `PC_STEP_COMPACT : `PC_STEP_WIDE);
        end
    end

    // PC, state flag, mode and link register update
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            // Reset behaves as an exception into wide state
            pc         <= `VEC_RESET;
            stateFlag  <= `STATE_WIDE;
            procMode   <= `MODE_SVC;
            savedState <= 6'h00;
            linkValue  <= 32'h00000000;
            linkWrite  <= 1'b0;
            for (i = 0; i < 6; i = i + 1)
                savedMode[i] <= `MODE_SVC;
        end
        else
        begin
            pc        <= next_pc;
            stateFlag <= next_state;
            linkWrite <= 1'b0;
            if (excReq)
            begin
                // PC goes to the banked link of the new mode
                linkValue          <= pc;
                linkWrite          <= 1'b1;
                procMode           <= excMode;
                savedState[excSlot] <= stateFlag;
                savedMode[excSlot] <= procMode;
            end
            else if (excReturn && curSlot != 3'h5)
                procMode <= savedMode[curSlot];
            // Branch-exchange touches only PC and state, never mode
        end
    end

    // Fetch and instruction issue
    // The request stays up until the word arrives; a flow change
    // keeps it up so the new path is fetched without a gap.
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            fetchReq     <= 1'b0;
            instrOut     <= 32'h00000000;
            instrValid   <= 1'b0;
            instrCompact <= `STATE_WIDE;
        end
        else if (excReq || excReturn || branchExchange || (instrValid && advance))
        begin
            // Flow change or consumed: drop the held instruction, refetch
            instrValid <= 1'b0;
            fetchReq   <= 1'b1;
        end
        else if (fetchReq && fetchValid)
        begin
            fetchReq     <= 1'b0;
            instrValid   <= 1'b1;
            instrCompact <= stateFlag;
            if (stateFlag == `STATE_COMPACT)
                instrOut <= {16'h0000, halfSel};
            else
                instrOut <= fetchWord;
        end
        else if (!instrValid)
            fetchReq <= 1'b1;
    end
endmodule // instruction_state_switch

// >>> sim/instruction_state_switch_assertions.sv
// Concurrent checks on the instruction-state switch ports
`include "instr_state_regs.vh"
module instruction_state_switch_assertions
(
    // Single-bit controls and status
    input wire        clk, nrst, bigEndian, fetchReq, fetchValid, instrValid,
    input wire        instrCompact, advance, branchExchange, excReq, excReturn,
    input wire        stateFlag, linkWrite,
    // Wide fields
    input wire [31:0] fetchAddr, fetchWord, instrOut, branchOperand, excReturnAddr,
    input wire [31:0] linkValue, pc,
    input wire [2:0]  excCause,
    input wire [4:0]  procMode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // No flow event competes with a fetch answer
    wire quiet = !excReq && !excReturn && !branchExchange && !advance;
    reg  [31:0] pcLast, wordLast;   // Previous pc and bus word
    reg  [15:0] halfPick;           // Halfword lane the state should pick
    reg         flagLast, opBit;    // Previous state, operand state bit
    // Helper copies so properties need no sliced past values
    always @(posedge clk)
    begin
        pcLast   <= pc;
        wordLast <= fetchWord;
        flagLast <= stateFlag;
        opBit    <= branchOperand[0];
        halfPick <= (pc[1] ^ bigEndian) ? fetchWord[31:16] : fetchWord[15:0];
    end
    sequence s_take_exc; excReq; endsequence
    sequence s_word_in; fetchValid && fetchReq && quiet; endsequence
    property p_align; fetchAddr == {pc[31:2], 2'h0}; endproperty
    a_align: assert property (p_align) else $error("fetch address misaligned");
    property p_wide; s_word_in and !stateFlag |=> instrValid && instrOut == wordLast; endproperty
    a_wide: assert property (p_wide) else $error("wide word not issued");
    property p_half; s_word_in and stateFlag |=> instrOut == {16'h0000, halfPick}; endproperty
    a_half: assert property (p_half) else $error("wrong halfword lane");
    property p_step; advance && instrValid && !excReq && !excReturn && !branchExchange
        |=> pc == pcLast + (flagLast ? 32'h00000002 : 32'h00000004); endproperty
    a_step: assert property (p_step) else $error("wrong pc step");
    property p_bx; branchExchange && !excReq && !excReturn
        |=> stateFlag == opBit && $stable(procMode); endproperty
    a_bx: assert property (p_bx) else $error("branch exchange state wrong");
    property p_exc; s_take_exc |=> !stateFlag && linkWrite && linkValue == pcLast; endproperty
    a_exc: assert property (p_exc) else $error("exception entry wrong");
    property p_vec; excReq && excCause == `EXC_SWI |=> pc == `VEC_SWI; endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_lw; linkWrite |-> $past(excReq); endproperty
    a_lw: assert property (p_lw) else $error("stray link write");
endmodule // instruction_state_switch_assertions
bind instruction_state_switch instruction_state_switch_assertions chk (.*);

// >>> sim/fetch_memory.sv
// Memory model answering instruction fetches, fast or slow
module fetch_memory
(
    input  wire        clk, fetchReq, slow,
    input  wire [31:0] fetchAddr,
    output logic       fetchValid,
    output logic [31:0] fetchWord
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;   // Wait states spent on this request
    initial {fetchValid, fetchWord, cnt} = '0;
    // Word answer only while requested; bus shows junk otherwise
    always @(posedge clk)
    begin
        if (fetchValid)
        begin
            fetchValid <= 1'b0;
            fetchWord  <= ~fetchWord;
        end
        else if (fetchReq && (!slow || cnt == 2'h3))
        begin
            fetchValid <= 1'b1;
            fetchWord  <= {~fetchAddr[15:2], 2'h3, fetchAddr[15:2], 2'h0};
            cnt        <= 2'h0;
        end
        else
        begin
            cnt       <= fetchReq ? cnt + 2'h1 : 2'h0;
            fetchWord <= ~fetchWord;
        end
    end
endmodule // fetch_memory

// >>> sim/test_instruction_state_switch.sv
// Self-checking bench for the instruction-state switch
`include "instr_state_regs.vh"
module test_instruction_state_switch;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, bigEndian, fetchReq, fetchValid, instrValid, instrCompact;
    logic        advance, branchExchange, excReq, excReturn, stateFlag, linkWrite, slow;
    logic [31:0] fetchAddr, fetchWord, instrOut, branchOperand, excReturnAddr, linkValue, pc;
    logic [2:0]  excCause;
    logic [4:0]  procMode;
    int          n_errors, num_checks, cyc;
    instruction_state_switch dut (.*);
    fetch_memory mem (.*);
    // Clock at 40 MHz
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Expected word the memory holds at an address
    function automatic [31:0] mw(input [31:0] a);
        mw = {~a[15:2], 2'h3, a[15:2], 2'h0};
    endfunction
    task automatic ck(input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // One event pulse: 1 bx, 2 exception, 3 return, 4 advance
    task automatic ev(input int k, input [31:0] d, input [2:0] c);
        @(posedge clk);
        #2;
        {branchExchange, excReq, excReturn, advance} = {k == 1, k == 2, k == 3, k == 4};
        {branchOperand, excReturnAddr, excCause} = {d, d, c};
        @(posedge clk);
        #2;
        {branchExchange, excReq, excReturn, advance} = 4'h0;
    endtask
    // Bounded wait for a fetched instruction
    task automatic wv();
        for (int i = 0; i < 40 && instrValid !== 1'b1; i++) @(posedge clk);
        #2;
        ck(32'h1, {31'h0, instrValid});
    endtask
    task automatic t_wide();
        ck(`PC_RESET, pc);
        ck(`MODE_SVC, {27'h0, procMode});
        wv();
        ck(mw(32'h0), instrOut);
        ck(32'h0, {31'h0, instrCompact});
        ev(4, 32'h0, 3'h0);
        ck(32'h4, pc);
    endtask
    // Compact run through both halves, in both byte orders
    task automatic t_compact(input logic be);
        logic [31:0] w;
        bigEndian = be;
        slow = be;
        ev(1, 32'h00000101, 3'h0);
        ck({31'h0, `STATE_COMPACT}, {31'h0, stateFlag});
        ck(`MODE_SVC, {27'h0, procMode});
        w = mw(32'h100);
        for (int h = 0; h < 2; h++)
        begin
            wv();
            ck({16'h0, (h[0] ^ be) ? w[31:16] : w[15:0]}, instrOut);
            ck(32'h1, {31'h0, instrCompact});
            ck(32'h100, fetchAddr);
            ev(4, 32'h0, 3'h0);
        end
        ck(32'h104, pc);
    endtask
    // Every exception taken from compact state, each but reset then returned from
    task automatic t_exc();
        logic [31:0] vec [7] = '{`VEC_RESET, `VEC_UNDEFINED_INSTRUCTION_TRAP, `VEC_SWI, `VEC_PABORT,
                                 `VEC_DABORT, `VEC_IRQ, `VEC_FIQ};
        logic [4:0]  md [7] = '{`MODE_SVC, `MODE_UND, `MODE_SVC, `MODE_ABT,
                                `MODE_ABT, `MODE_IRQ, `MODE_FIQ};
        for (int c = 6; c >= 0; c--)
        begin
            ev(1, 32'h00000201, 3'h0);
            wv();
            ev(2, 32'h0, c[2:0]);
            ck(vec[c], pc);
            ck(32'h200, linkValue);
            ck({md[c], 2'h2}, {procMode, linkWrite, stateFlag});
            if (c == 0) break;
            wv();
            ev(3, 32'h00000202, 3'h0);
            ck(32'h202, pc);
            ck(32'h1, {31'h0, stateFlag});
        end
        ev(1, 32'h00000300, 3'h0);
        ck(32'h300, pc);
        ck({31'h0, `STATE_WIDE}, {31'h0, stateFlag});
    endtask
    task automatic results();
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 4000)
        begin
            n_errors++;
            results();
        end
    end
    initial
    begin
        {nrst, bigEndian, slow, advance, branchExchange, excReq, excReturn} = 7'h0;
        {branchOperand, excReturnAddr, excCause} = '0;
        repeat (6) @(posedge clk);
        #2;
        nrst = 1'b1;
        t_wide();
        t_compact(1'b0);
        t_compact(1'b1);
        t_exc();
        results();
    end
endmodule // test_instruction_state_switch
